// [mmu_tlb_unit.sv]
// Translation unit: four-way TLB, staging registers, exception checks
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
module mmu_tlb_unit #(
	parameter int WAYS = mmu_pkg::WAYS,
	parameter int SETS = mmu_pkg::SETS
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	mmu_link_if.unit link
);
	logic [31:0] cr_ff;
	logic [31:0] hi_ff;
	logic [31:0] lo_ff;
	logic [SETS-1:0] valid_ff [WAYS];
	logic [31:0] ehi [WAYS][SETS];
	logic [31:0] elo [WAYS][SETS];
	logic done_ff;
	logic [31:0] pa_ff;
	mmu_pkg::exc_t exc_ff;
	logic cache_ff;
	logic [6:0] cidx_ff;
	logic [21:0] ctag_ff;
	logic [31:0] rd_hi_ff;
	logic [31:0] rd_lo_ff;
	logic [WAYS-1:0] match;
	logic [WAYS-1:0] hit;
	logic [1:0] hit_way;
	logic [1:0] free_way;
	logic any_free;
	mmu_pkg::exc_t nxt_exc;
	logic [31:0] nxt_pa;
	logic nxt_cache;
	logic [31:0] hlo;
	logic [1:0] nxt_rc;
	wire [31:0] va = link.acc_va;
	wire at_on = cr_ff[mmu_pkg::CR_AT];
	wire ix_on = cr_ff[mmu_pkg::CR_IX];
	wire sv_on = cr_ff[mmu_pkg::CR_SV];
	wire [1:0] rc = cr_ff[mmu_pkg::CR_RC_HI:mmu_pkg::CR_RC_LO];
	wire [7:0] asid = hi_ff[mmu_pkg::ASID_W-1:0];
	wire [4:0] idx = va[16:12] ^ (ix_on ? asid[4:0] : 5'h00);
	wire [4:0] ld_idx = hi_ff[16:12] ^ (ix_on ? asid[4:0] : 5'h00);
	wire fixed = va[31:30] == mmu_pkg::FIXED_TOP;
	wire bypass = !at_on || fixed;
	wire flush = link.reg_wr && link.reg_sel == mmu_pkg::SEL_CR
		&& link.reg_wdata[mmu_pkg::CR_TF];
	wire raise = link.acc_req && nxt_exc != mmu_pkg::EXC_NONE;
	assign link.cr_val = cr_ff;
	assign link.hi_val = hi_ff;
	assign link.lo_val = lo_ff;
	assign link.acc_done = done_ff;
	assign link.acc_pa = pa_ff;
	assign link.acc_exc = exc_ff;
	assign link.acc_cache = cache_ff;
	assign link.cache_idx = cidx_ff;
	assign link.cache_tag = ctag_ff;
	assign link.mm_rd_hi = rd_hi_ff;
	assign link.mm_rd_lo = rd_lo_ff;
	for (genvar w = 0; w < WAYS; w++)
	begin : g_cmp
		wire [31:0] eh = ehi[w][idx];
		wire sz = elo[w][idx][mmu_pkg::LO_SZ];
		wire vpn_eq = eh[31:12] == va[31:12]
			&& (sz || eh[11:10] == va[11:10]);
		wire asid_ok = elo[w][idx][mmu_pkg::LO_SH]
			|| (sv_on && link.acc_priv)
			|| eh[7:0] == asid;
		assign match[w] = vpn_eq && asid_ok;
		assign hit[w] = match[w] && valid_ff[w][idx];
	end
	always_comb
	begin
		hit_way = 2'h0;
		free_way = 2'h0;
		any_free = 1'b0;
		for (int w = WAYS - 1; w >= 0; w--)
		begin
			if (match[w])
				hit_way = w[1:0];
			if (!valid_ff[w][idx])
			begin
				free_way = w[1:0];
				any_free = 1'b1;
			end
		end
	end
	always_comb
	begin
		hlo = elo[hit_way][idx];
		nxt_exc = mmu_pkg::EXC_NONE;
		nxt_rc = rc;
		if (hlo[mmu_pkg::LO_SZ])
			nxt_pa = {hlo[31:12], va[11:0]};
		else
			nxt_pa = {hlo[31:10], va[9:0]};
		nxt_cache = hlo[mmu_pkg::LO_C];
		if (bypass)
		begin
			nxt_pa = fixed ? {3'h0, va[28:0]} : va;
			nxt_cache = !fixed || !va[29];
		end
		else if (match == '0)
		begin
			nxt_exc = mmu_pkg::EXC_MISS;
			nxt_rc = any_free ? free_way : rc + 2'h1;
		end
		else
		begin
			nxt_rc = hit_way;
			if (hit == '0)
				nxt_exc = mmu_pkg::EXC_INVALID;
			else if (link.acc_priv ? (link.acc_write
				&& !hlo[mmu_pkg::LO_PR_LO])
				: (link.acc_write ? hlo[6:5] != 2'h3
				: !hlo[mmu_pkg::LO_PR_LO+1]))
				nxt_exc = mmu_pkg::EXC_PROT;
			else if (link.acc_write && !hlo[mmu_pkg::LO_D])
				nxt_exc = mmu_pkg::EXC_INITWR;
		end
	end
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			cr_ff <= mmu_pkg::CR_RST;
			hi_ff <= mmu_pkg::HI_RST;
			lo_ff <= mmu_pkg::LO_RST;
		end
		else
		begin
			if (link.reg_wr && link.reg_sel == mmu_pkg::SEL_CR)
				cr_ff <= link.reg_wdata & ~(32'h1 << mmu_pkg::CR_TF);
			if (link.reg_wr && link.reg_sel == mmu_pkg::SEL_HI)
				hi_ff <= link.reg_wdata;
			if (link.reg_wr && link.reg_sel == mmu_pkg::SEL_LO)
				lo_ff <= link.reg_wdata;
			if (raise)
			begin
				hi_ff[31:mmu_pkg::HI_VPN_LO] <= va[31:10];
				cr_ff[mmu_pkg::CR_RC_HI:mmu_pkg::CR_RC_LO] <= nxt_rc;
			end
		end
	end
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			for (int w = 0; w < WAYS; w++)
				valid_ff[w] <= '0;
		end
		else if (flush)
		begin
			for (int w = 0; w < WAYS; w++)
				valid_ff[w] <= '0;
		end
		else if (link.load_entry)
			valid_ff[rc][ld_idx] <= lo_ff[mmu_pkg::LO_V];
		else if (link.mm_wr)
			valid_ff[link.mm_way][link.mm_idx] <= link.mm_lo[mmu_pkg::LO_V];
		else if (link.mm_inv)
			valid_ff[link.mm_way][link.mm_idx] <= 1'b0;
	end
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			// Cleared so that no lookup compares unknown tags
			for (int w = 0; w < WAYS; w++)
			begin
				for (int s = 0; s < SETS; s++)
				begin
					ehi[w][s] <= 32'h0000_0000;
					elo[w][s] <= 32'h0000_0000;
				end
			end
		end
		else if (link.load_entry)
		begin
			ehi[rc][ld_idx] <= hi_ff;
			elo[rc][ld_idx] <= lo_ff;
		end
		else if (link.mm_wr)
		begin
			ehi[link.mm_way][link.mm_idx] <= link.mm_hi;
			elo[link.mm_way][link.mm_idx] <= link.mm_lo;
		end
	end
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			done_ff <= 1'b0;
			pa_ff <= 32'h0000_0000;
			exc_ff <= mmu_pkg::EXC_NONE;
			cache_ff <= 1'b0;
			cidx_ff <= 7'h00;
			ctag_ff <= 22'h000000;
			rd_hi_ff <= 32'h0000_0000;
			rd_lo_ff <= 32'h0000_0000;
		end
		else
		begin
			done_ff <= link.acc_req;
			if (link.acc_req)
			begin
				pa_ff <= nxt_pa;
				exc_ff <= nxt_exc;
				cache_ff <= nxt_cache && nxt_exc == mmu_pkg::EXC_NONE;
				cidx_ff <= va[mmu_pkg::CIDX_HI:mmu_pkg::CIDX_LO];
				ctag_ff <= nxt_pa[31:mmu_pkg::CTAG_LO];
			end
			if (link.mm_rd)
			begin
				rd_hi_ff <= ehi[link.mm_way][link.mm_idx];
				rd_lo_ff <= {elo[link.mm_way][link.mm_idx][31:9],
					valid_ff[link.mm_way][link.mm_idx],
					elo[link.mm_way][link.mm_idx][7:0]};
			end
		end
	end
endmodule : mmu_tlb_unit

// [mmu_pkg.sv]
// Shared constants and types for the translation unit and its core end
package mmu_pkg;
	localparam int VA_W = 32;
	localparam int WAYS = 4;
	localparam int SETS = 32;
	localparam int IDX_W = 5;
	// Control register fields
	localparam int CR_AT = 0;
	localparam int CR_IX = 1;
	localparam int CR_TF = 2;
	localparam int CR_RC_LO = 6;
	localparam int CR_RC_HI = 7;
	localparam int CR_SV = 8;
	localparam logic [31:0] CR_RST = 32'h0000_0000;
	// Entry-high stage: page number 31..10, address space id 7..0
	localparam int HI_VPN_LO = 10;
	localparam int HI_IDX_LO = 12;
	localparam int ASID_W = 8;
	localparam logic [31:0] HI_RST = 32'h0000_0000;
	// Entry-low stage: frame number 31..10 and page flags
	localparam int LO_SH = 1;
	localparam int LO_D = 2;
	localparam int LO_C = 3;
	localparam int LO_SZ = 4;
	localparam int LO_PR_LO = 5;
	localparam int LO_V = 8;
	localparam logic [31:0] LO_RST = 32'h0000_0000;
	// Cache indexing
	localparam int CIDX_HI = 10;
	localparam int CIDX_LO = 4;
	localparam int CTAG_LO = 10;
	// Register selects on the link
	localparam logic [1:0] SEL_CR = 2'h0;
	localparam logic [1:0] SEL_HI = 2'h1;
	localparam logic [1:0] SEL_LO = 2'h2;
	// Fixed untranslated areas: top bits 2'b10
	localparam logic [1:0] FIXED_TOP = 2'h2;
	// Spacing after an entry load, in clock cycles
	localparam logic [1:0] LOAD_GAP = 2'h2;
	// Software port offsets of the core end
	localparam logic [7:0] A_CR = 8'h00;
	localparam logic [7:0] A_HI = 8'h04;
	localparam logic [7:0] A_LO = 8'h08;
	localparam logic [7:0] A_CMD = 8'h0C;
	localparam logic [7:0] A_VA = 8'h10;
	localparam logic [7:0] A_CTL = 8'h14;
	localparam logic [7:0] A_PA = 8'h18;
	localparam logic [7:0] A_STAT = 8'h1C;
	typedef enum logic [2:0] {
		EXC_NONE, EXC_MISS, EXC_INVALID, EXC_PROT, EXC_INITWR
	} exc_t;
endpackage : mmu_pkg

// [mmu_link_if.sv]
// Link between the core end and the translation unit
interface mmu_link_if;
	logic reg_wr;
	logic [1:0] reg_sel;
	logic [31:0] reg_wdata;
	logic load_entry;
	logic [31:0] cr_val;
	logic [31:0] hi_val;
	logic [31:0] lo_val;
	logic acc_req;
	logic [31:0] acc_va;
	logic acc_write;
	logic acc_priv;
	logic acc_done;
	logic [31:0] acc_pa;
	mmu_pkg::exc_t acc_exc;
	logic acc_cache;
	logic [6:0] cache_idx;
	logic [21:0] cache_tag;
	logic mm_wr;
	logic mm_inv;
	logic mm_rd;
	logic [1:0] mm_way;
	logic [4:0] mm_idx;
	logic [31:0] mm_hi;
	logic [31:0] mm_lo;
	logic [31:0] mm_rd_hi;
	logic [31:0] mm_rd_lo;
	modport unit (input reg_wr, reg_sel, reg_wdata, load_entry, acc_req,
		acc_va, acc_write, acc_priv, mm_wr, mm_inv, mm_rd, mm_way, mm_idx,
		mm_hi, mm_lo, output cr_val, hi_val, lo_val, acc_done, acc_pa,
		acc_exc, acc_cache, cache_idx, cache_tag, mm_rd_hi, mm_rd_lo);
	modport core (output reg_wr, reg_sel, reg_wdata, load_entry, acc_req,
		acc_va, acc_write, acc_priv, mm_wr, mm_inv, mm_rd, mm_way, mm_idx,
		mm_hi, mm_lo, input cr_val, hi_val, lo_val, acc_done, acc_pa,
		acc_exc, acc_cache, cache_idx, cache_tag, mm_rd_hi, mm_rd_lo);
endinterface : mmu_link_if

// [mmu_core_end.sv]
// Core end: software port, ordering and spacing of unit operations
module mmu_core_end (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	mmu_link_if.core link
);
	logic [31:0] va_ff;
	logic [2:0] ctl_ff;
	logic [31:0] pa_ff;
	logic [2:0] exc_ff;
	logic cache_ff;
	logic done_ff;
	logic refused_ff;
	logic pend_ff;
	logic [1:0] gap_ff;
	logic reg_wr_ff;
	logic [1:0] sel_ff;
	logic [31:0] wd_ff;
	logic load_ff;
	logic req_ff;
	logic [31:0] nxt_rdata;
	// ctl bit0 write, bit1 privileged, bit2 code runs from a fixed area
	wire fixed_code = ctl_ff[2];
	wire wr_cr = wr_in && addr_in == mmu_pkg::A_CR;
	wire wr_hi = wr_in && addr_in == mmu_pkg::A_HI;
	wire wr_lo = wr_in && addr_in == mmu_pkg::A_LO;
	wire wr_cmd = wr_in && addr_in == mmu_pkg::A_CMD;
	wire cr_ok = wr_cr && fixed_code;
	wire load_ok = wr_cmd && wdata_in[0] && fixed_code;
	wire bad = (wr_cr && !fixed_code) || (wr_cmd && wdata_in[0]
		&& !fixed_code);
	wire scheme_chg = wdata_in[mmu_pkg::CR_SV] != link.cr_val[mmu_pkg::CR_SV]
		|| wdata_in[mmu_pkg::CR_IX] != link.cr_val[mmu_pkg::CR_IX];
	wire [31:0] cr_wd = scheme_chg ? (wdata_in | (32'h1 << mmu_pkg::CR_TF))
		: wdata_in;
	wire va_fixed = va_ff[31:30] == mmu_pkg::FIXED_TOP;
	wire want = pend_ff || (wr_cmd && wdata_in[1]);
	wire go = want && (gap_ff == 2'h0 || va_fixed) && !req_ff;
	assign link.reg_wr = reg_wr_ff;
	assign link.reg_sel = sel_ff;
	assign link.reg_wdata = wd_ff;
	assign link.load_entry = load_ff;
	assign link.acc_req = req_ff;
	assign link.acc_va = va_ff;
	assign link.acc_write = ctl_ff[0];
	assign link.acc_priv = ctl_ff[1];
	assign link.mm_wr = 1'b0;
	assign link.mm_inv = 1'b0;
	assign link.mm_rd = 1'b0;
	assign link.mm_way = 2'h0;
	assign link.mm_idx = 5'h00;
	assign link.mm_hi = 32'h0000_0000;
	assign link.mm_lo = 32'h0000_0000;
	always_comb
	begin
		unique case (addr_in)
			mmu_pkg::A_CR: nxt_rdata = link.cr_val;
			mmu_pkg::A_HI: nxt_rdata = link.hi_val;
			mmu_pkg::A_LO: nxt_rdata = link.lo_val;
			mmu_pkg::A_VA: nxt_rdata = va_ff;
			mmu_pkg::A_CTL: nxt_rdata = {29'h0, ctl_ff};
			mmu_pkg::A_PA: nxt_rdata = pa_ff;
			mmu_pkg::A_STAT: nxt_rdata = {25'h0, pend_ff, refused_ff,
				cache_ff, done_ff, exc_ff};
			default: nxt_rdata = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rdata_out <= 32'h0000_0000;
			va_ff <= 32'h0000_0000;
			ctl_ff <= 3'h0;
			reg_wr_ff <= 1'b0;
			sel_ff <= 2'h0;
			wd_ff <= 32'h0000_0000;
			load_ff <= 1'b0;
			gap_ff <= 2'h0;
		end
		else
		begin
			rdata_out <= rd_in ? nxt_rdata : 32'h0000_0000;
			if (wr_in && addr_in == mmu_pkg::A_VA)
				va_ff <= wdata_in;
			if (wr_in && addr_in == mmu_pkg::A_CTL)
				ctl_ff <= wdata_in[2:0];
			reg_wr_ff <= cr_ok || wr_hi || wr_lo;
			sel_ff <= wr_hi ? mmu_pkg::SEL_HI : wr_lo ? mmu_pkg::SEL_LO
				: mmu_pkg::SEL_CR;
			wd_ff <= wr_cr ? cr_wd : wdata_in;
			load_ff <= load_ok;
			if (load_ok)
				gap_ff <= mmu_pkg::LOAD_GAP;
			else if (gap_ff != 2'h0)
				gap_ff <= gap_ff - 2'h1;
		end
	end
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			req_ff <= 1'b0;
			pend_ff <= 1'b0;
			pa_ff <= 32'h0000_0000;
			exc_ff <= 3'h0;
			cache_ff <= 1'b0;
			done_ff <= 1'b0;
			refused_ff <= 1'b0;
		end
		else
		begin
			req_ff <= go;
			pend_ff <= want && !go;
			if (bad)
				refused_ff <= 1'b1;
			else if (wr_cmd && wdata_in[2])
				refused_ff <= 1'b0;
			if (link.acc_done)
			begin
				pa_ff <= link.acc_pa;
				exc_ff <= link.acc_exc;
				cache_ff <= link.acc_cache;
				done_ff <= 1'b1;
			end
			else if (go)
				done_ff <= 1'b0;
		end
	end
endmodule : mmu_core_end

// [mmu_tlb_checker.sv]
// Assertions on the link between the core end and the translation unit
module mmu_tlb_checker (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic reg_wr,
	input wire logic [1:0] reg_sel,
	input wire logic [31:0] reg_wdata,
	input wire logic load_entry,
	input wire logic [31:0] cr_val,
	input wire logic [31:0] hi_val,
	input wire logic acc_req,
	input wire logic [31:0] acc_va,
	input wire logic acc_done,
	input wire logic [31:0] acc_pa,
	input wire mmu_pkg::exc_t acc_exc,
	input wire logic acc_cache,
	input wire logic [6:0] cache_idx,
	input wire logic [21:0] cache_tag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	wire exc_w = acc_exc != mmu_pkg::EXC_NONE;
	wire fix_w = acc_va[31:30] == mmu_pkg::FIXED_TOP;
	wire cr_wr_w = reg_wr && reg_sel == mmu_pkg::SEL_CR;
	wire sv_w = reg_wdata[mmu_pkg::CR_SV] != cr_val[mmu_pkg::CR_SV];
	wire ix_w = reg_wdata[mmu_pkg::CR_IX] != cr_val[mmu_pkg::CR_IX];
	property p_done;
		acc_req |=> acc_done;
	endproperty
	a_done: assert property (p_done) else $error("no result");
	property p_fixed;
		acc_req && fix_w |=> !exc_w && acc_pa == {3'h0, $past(acc_va[28:0])}
			&& acc_cache == !$past(acc_va[29]);
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed area");
	property p_off;
		acc_req && !fix_w && !cr_val[mmu_pkg::CR_AT]
			|=> !exc_w && acc_pa == $past(acc_va);
	endproperty
	a_off: assert property (p_off) else $error("unit off");
	property p_nocache;
		acc_done && exc_w |-> !acc_cache;
	endproperty
	a_nocache: assert property (p_nocache) else $error("cache on fault");
	property p_idx;
		acc_done |-> cache_idx == $past(acc_va[10:4]);
	endproperty
	a_idx: assert property (p_idx) else $error("cache index");
	property p_tag;
		acc_done |-> cache_tag == acc_pa[31:10];
	endproperty
	a_tag: assert property (p_tag) else $error("cache tag");
	property p_hi;
		acc_done && exc_w |-> hi_val[31:10] == $past(acc_va[31:10]);
	endproperty
	a_hi: assert property (p_hi) else $error("stage page");
	property p_tf;
		cr_wr_w |=> !cr_val[mmu_pkg::CR_TF];
	endproperty
	a_tf: assert property (p_tf) else $error("flush bit stuck");
	property p_scheme;
		cr_wr_w && (sv_w || ix_w) |-> reg_wdata[mmu_pkg::CR_TF];
	endproperty
	a_scheme: assert property (p_scheme) else $error("no flush");
	property p_gap;
		load_entry |=> !acc_req || fix_w;
	endproperty
	a_gap: assert property (p_gap) else $error("access too soon");
endmodule : mmu_tlb_checker

// [mmu_tlb_load_and_translate_tb.sv]
// Bench for the translation unit and its core end
module mmu_tlb_load_and_translate_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [7:0] addr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0000_0000;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [31:0] rdata_out;
	logic [31:0] d;
	logic [31:0] st;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected at %0t: got %h want %h", $time, g, e); end end
	mmu_link_if mmu_link_if_i ();
	mmu_core_end mmu_core_end_i (.clk_in(clk_in), .rstn_in(rstn_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out), .link(mmu_link_if_i));
	mmu_tlb_unit mmu_tlb_unit_i (.clk_in(clk_in), .rstn_in(rstn_in),
		.link(mmu_link_if_i));
	mmu_tlb_checker mmu_tlb_checker_i (.clk_in(clk_in), .rstn_in(rstn_in),
		.reg_wr(mmu_link_if_i.reg_wr), .reg_sel(mmu_link_if_i.reg_sel),
		.reg_wdata(mmu_link_if_i.reg_wdata), .cr_val(mmu_link_if_i.cr_val),
		.load_entry(mmu_link_if_i.load_entry), .hi_val(mmu_link_if_i.hi_val),
		.acc_req(mmu_link_if_i.acc_req), .acc_va(mmu_link_if_i.acc_va),
		.acc_done(mmu_link_if_i.acc_done), .acc_pa(mmu_link_if_i.acc_pa),
		.acc_exc(mmu_link_if_i.acc_exc), .acc_cache(mmu_link_if_i.acc_cache),
		.cache_idx(mmu_link_if_i.cache_idx),
		.cache_tag(mmu_link_if_i.cache_tag));
	always #2 clk_in = ~clk_in;
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			err_total++;
			report_and_stop;
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= v;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		d = rdata_out;
	endtask : rd
	task automatic ld(input logic [31:0] cr, hi, lo);
		wr(mmu_pkg::A_CR, cr);
		wr(mmu_pkg::A_HI, hi);
		wr(mmu_pkg::A_LO, lo);
		wr(mmu_pkg::A_CMD, 32'h0000_0001);
	endtask : ld
	task automatic acc(input logic [31:0] va, ctl, pa,
		input mmu_pkg::exc_t ex);
		wr(mmu_pkg::A_CTL, ctl);
		wr(mmu_pkg::A_VA, va);
		wr(mmu_pkg::A_CMD, 32'h0000_0002);
		rd(mmu_pkg::A_STAT);
		for (int i = 0; i < 8 && (d[3] !== 1'b1 || d[6] !== 1'b0); i++)
			rd(mmu_pkg::A_STAT);
		st = d;
		`CHK(st[3], 1'b1)
		`CHK(st[2:0], ex)
		if (ex == mmu_pkg::EXC_NONE)
		begin
			rd(mmu_pkg::A_PA);
			`CHK(d, pa)
		end
	endtask : acc
	task automatic exc_chk(input logic [31:0] va, input logic [1:0] rc);
		rd(mmu_pkg::A_HI);
		`CHK(d[31:10], va[31:10])
		rd(mmu_pkg::A_CR);
		`CHK(d[7:6], rc)
	endtask : exc_chk
	task automatic t_off_refuse;
		rd(mmu_pkg::A_CR);
		`CHK(d, 32'h0000_0000)
		acc(32'h1234_5678, 32'h0000_0005, 32'h1234_5678, mmu_pkg::EXC_NONE);
		wr(mmu_pkg::A_CTL, 32'h0000_0000);
		wr(mmu_pkg::A_CR, 32'h0000_0001);
		wr(mmu_pkg::A_CMD, 32'h0000_0001);
		rd(mmu_pkg::A_STAT);
		`CHK(d[5], 1'b1)
		rd(mmu_pkg::A_CR);
		`CHK(d[0], 1'b0)
		wr(mmu_pkg::A_CMD, 32'h0000_0004);
		wr(mmu_pkg::A_CTL, 32'h0000_0004);
		wr(mmu_pkg::A_CR, 32'h0000_0001);
		$display("test off_refuse done");
	endtask : t_off_refuse
	task automatic t_faults;
		acc(32'h0000_3454, 32'h0000_0004, 32'h0, mmu_pkg::EXC_MISS);
		exc_chk(32'h0000_3454, 2'h0);
		wr(mmu_pkg::A_LO, 32'h00AB_C17C);
		wr(mmu_pkg::A_CMD, 32'h0000_0001);
		acc(32'h0000_3454, 32'h5, 32'h00AB_C454, mmu_pkg::EXC_NONE);
		`CHK(st[4], 1'b1)
		acc(32'h0002_3000, 32'h0000_0004, 32'h0, mmu_pkg::EXC_MISS);
		exc_chk(32'h0002_3000, 2'h1);
		wr(mmu_pkg::A_LO, 32'h00B0_011C);
		wr(mmu_pkg::A_CMD, 32'h0000_0001);
		acc(32'h0002_3000, 32'h0000_0004, 32'h0, mmu_pkg::EXC_PROT);
		acc(32'h0002_3000, 32'h0000_0007, 32'h0, mmu_pkg::EXC_PROT);
		exc_chk(32'h0002_3000, 2'h1);
		acc(32'h0002_3000, 32'h6, 32'h00B0_0000, mmu_pkg::EXC_NONE);
		ld(32'h0000_0081, 32'h0004_3000, 32'h00B4_0178);
		acc(32'h0004_3000, 32'h0000_0005, 32'h0, mmu_pkg::EXC_INITWR);
		exc_chk(32'h0004_3000, 2'h2);
		ld(32'h0000_00C1, 32'h0006_3000, 32'h0000_007C);
		acc(32'h0006_3000, 32'h4, 32'h0, mmu_pkg::EXC_INVALID);
		exc_chk(32'h0006_3000, 2'h3);
		$display("test faults done");
	endtask : t_faults
	task automatic t_asid;
		ld(32'h0000_0001, 32'h0008_5005, 32'h00D0_017C);
		acc(32'h0008_5000, 32'h4, 32'h00D0_0000, mmu_pkg::EXC_NONE);
		wr(mmu_pkg::A_HI, 32'h0008_5006);
		acc(32'h0008_5000, 32'h4, 32'h0, mmu_pkg::EXC_MISS);
		ld(32'h0000_0001, 32'h0008_6005, 32'h00D4_017E);
		wr(mmu_pkg::A_HI, 32'h0008_6006);
		acc(32'h0008_6000, 32'h4, 32'h00D4_0000, mmu_pkg::EXC_NONE);
		wr(mmu_pkg::A_CR, 32'h0000_0101);
		acc(32'h0008_6000, 32'h4, 32'h0, mmu_pkg::EXC_INVALID);
		ld(32'h0000_0101, 32'h0008_5005, 32'h00D0_017C);
		wr(mmu_pkg::A_HI, 32'h0008_5006);
		acc(32'h0008_5000, 32'h6, 32'h00D0_0000, mmu_pkg::EXC_NONE);
		acc(32'h0008_5000, 32'h4, 32'h0, mmu_pkg::EXC_MISS);
		$display("test asid done");
	endtask : t_asid
	task automatic t_index_size;
		wr(mmu_pkg::A_CR, 32'h0000_0003);
		ld(32'h0000_0003, 32'h0000_7003, 32'h00E0_017E);
		acc(32'h0000_7000, 32'h4, 32'h00E0_0000, mmu_pkg::EXC_NONE);
		wr(mmu_pkg::A_HI, 32'h0000_7000);
		acc(32'h0000_7000, 32'h4, 32'h0, mmu_pkg::EXC_MISS);
		wr(mmu_pkg::A_CR, 32'h0000_0001);
		ld(32'h0000_0001, 32'h0000_9400, 32'h00C0_016C);
		acc(32'h0000_9404, 32'h4, 32'h00C0_0004, mmu_pkg::EXC_NONE);
		acc(32'h0000_9004, 32'h4, 32'h0, mmu_pkg::EXC_MISS);
		acc(32'h8000_1234, 32'h4, 32'h0000_1234, mmu_pkg::EXC_NONE);
		`CHK(st[4], 1'b1)
		acc(32'hA000_1234, 32'h4, 32'h0000_1234, mmu_pkg::EXC_NONE);
		`CHK(st[4], 1'b0)
		$display("test index_size done");
	endtask : t_index_size
	initial
	begin
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'b1;
		wr(mmu_pkg::A_CTL, 32'h0000_0004);
		t_off_refuse;
		t_faults;
		t_asid;
		t_index_size;
		report_and_stop;
	end
endmodule : mmu_tlb_load_and_translate_tb
